// File: inc/wea_pkg.sv
package wea_pkg;
  // Status/enable register width, GPIO and either-edge source counts
  localparam int WEA_REG_W     = 8;
  localparam int WEA_GPIO_N    = 8;
  localparam int WEA_EITHER_EDGE_IRQ_N    = 2;
  // Wake status 1 bit positions
  localparam int WEA_S1_PWRBTN = 0;
  localparam int WEA_S1_PLOSS  = 1;
  localparam int WEA_S1_RI_A   = 2;
  localparam int WEA_S1_RI_B   = 3;
  localparam int WEA_S1_HWM    = 4;
  localparam int WEA_S1_WDT    = 5;
  localparam int WEA_S1_LOWBAT = 6;
  // Wake status 3 bit positions
  localparam int WEA_S3_GPIO   = 0;
  localparam int WEA_S3_GROUP  = 3;
  // Wake status 6 bit positions (either-edge sources)
  localparam int WEA_S6_EETI0  = 0;
  // Shared pin control bit positions
  localparam int WEA_CTL_POL   = 1;
  localparam int WEA_CTL_OD    = 7;
  // Reset values
  localparam logic [WEA_REG_W-1:0] WEA_EN_RST     = 8'h00;
  localparam logic [WEA_REG_W-1:0] WEA_PIN_CTL_RST = 8'h80;
  localparam logic                 WEA_PIN_EN_RST = 1'b0;
endpackage

// File: inc/wea_sync_if.sv
`timescale 1ns/1ns
`default_nettype none
interface wea_sync_if;
  import wea_pkg::*;
  logic [WEA_GPIO_N+1:0] raw;
  logic [WEA_GPIO_N+1:0] synced;
  modport src (output raw, input synced);
  modport snk (input raw, output synced);
endinterface
`default_nettype wire

// File: core/wea_sync.sv
`timescale 1ns/1ns
`default_nettype none
module wea_sync
  import wea_pkg::*;
(
  input  wire logic sys_clk_i, // System clock
  input  wire logic reset_i,   // Synchronous reset
  wea_sync_if.snk   port_if    // Raw in, synced out
);
  logic [WEA_GPIO_N+1:0] meta_q;
  logic [WEA_GPIO_N+1:0] meta_d;
  logic [WEA_GPIO_N+1:0] sync_q;
  logic [WEA_GPIO_N+1:0] sync_d;

  always_comb
  begin
    meta_d = port_if.raw;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign port_if.synced = sync_q;
endmodule
`default_nettype wire

// File: core/wea_core.sv
// Overview of operation
// - Wake pin requests wake, works in S5
// - Status bits sticky, cleared by writing one, except status 3 bit 3
// - Pin status set by any enabled status
// - Pin asserts on pin status and enable
// - GPIO polarity selects setting edge
// - Either-edge GPIO sets on both edges
// - Hardware monitor has status and enable
// - Status 3 bit 3 mirrors routed group
// - Enable 3 bit 3 qualifies group source
// - Shared pin polarity selects active level
// - Control bit 7 selects open drain
// - Reset: active low, open drain, GPIO function
// - Sources: button, loss, ring, group, monitor, watchdog
// - Low battery only at main power-on
// - Output-configured GPIOs never set status
// - Either-edge sources own status 6 bits
`timescale 1ns/1ns
`default_nettype none
module wea_core
  import wea_pkg::*;
(
  input  wire logic                  sys_clk_i,             // System clock, 125 MHz
  input  wire logic                  reset_i,               // VTR power-on reset
  input  wire logic                  power_button_n_i,      // Power button, pin
  input  wire logic                  power_loss_event_i,    // Return from power loss pulse
  input  wire logic                  ring_indicator_a_n_i,  // Ring indicator A, pin
  input  wire logic                  ring_indicator_b_n_i,  // Ring indicator B, pin
  input  wire logic                  hw_monitor_irq_n_i,    // Hardware monitor interrupt
  input  wire logic                  watchdog_event_i,      // Watchdog timeout pulse
  input  wire logic                  low_battery_i,         // Low battery level
  input  wire logic                  main_por_event_i,      // Main supply power-on pulse
  input  wire logic                  group_irq_i,           // Internal group mgmt interrupt
  input  wire logic                  mgmt_irq_enable_2_i,   // Group routing bit
  input  wire logic [WEA_GPIO_N-1:0] gpio_i,                // Wake GPIO pins
  input  wire logic [WEA_GPIO_N-1:0] gpio_dir_out_i,        // GPIO is output
  input  wire logic [WEA_GPIO_N-1:0] gpio_pol_i,            // GPIO inverted polarity
  input  wire logic [WEA_EITHER_EDGE_IRQ_N-1:0] either_edge_irq_gpio_i,           // Either-edge pins
  input  wire logic [WEA_EITHER_EDGE_IRQ_N-1:0] either_edge_irq_sel_i, // Either-edge selected
  input  wire logic [WEA_REG_W-1:0]  wake_status_1_clr_i,   // Write-one-to-clear strobes
  input  wire logic [WEA_REG_W-1:0]  wake_status_3_clr_i,   // Write-one-to-clear strobes
  input  wire logic [WEA_REG_W-1:0]  wake_status_5_clr_i,   // Write-one-to-clear strobes
  input  wire logic [WEA_REG_W-1:0]  wake_status_6_clr_i,   // Write-one-to-clear strobes
  input  wire logic [WEA_REG_W-1:0]  wake_enable_1_i,       // Enable 1
  input  wire logic [WEA_REG_W-1:0]  wake_enable_3_i,       // Enable 3
  input  wire logic [WEA_REG_W-1:0]  wake_enable_5_i,       // Enable 5
  input  wire logic [WEA_REG_W-1:0]  wake_enable_6_i,       // Enable 6
  input  wire logic                  wake_pin_enable_i,     // Pin enable
  input  wire logic                  pin_ctl_we_i,          // Shared pin control write
  input  wire logic [WEA_REG_W-1:0]  pin_ctl_wdata_i,       // Shared pin control data
  input  wire logic                  wake_func_sel_i,       // Shared pin uses wake function
  input  wire logic                  shared_wake_gpio_o_i,  // GPIO output value
  input  wire logic                  shared_wake_gpio_oe_i, // GPIO output enable
  output logic [WEA_REG_W-1:0]       wake_status_1_o,       // Status 1, registered
  output logic [WEA_REG_W-1:0]       wake_status_3_o,       // Status 3
  output logic [WEA_REG_W-1:0]       wake_status_5_o,       // Status 5, registered
  output logic [WEA_REG_W-1:0]       wake_status_6_o,       // Status 6, registered
  output logic                       wake_pin_status_o,     // Pin status
  output logic [WEA_REG_W-1:0]       pin_ctl_o,             // Shared pin control, registered
  output logic                       shared_wake_gpio_o,    // Pin output value
  output logic                       shared_wake_gpio_oe_o  // Pin output enable
);
  localparam int SN = WEA_GPIO_N + WEA_EITHER_EDGE_IRQ_N;

  wea_sync_if          gsync ();
  logic [3:0]          misc_meta_q;
  logic [3:0]          misc_sync_q;
  logic [3:0]          misc_prev_q;
  logic [SN-1:0]       gprev_q;
  logic [3:0]          misc_meta_d;
  logic [3:0]          misc_sync_d;
  logic [3:0]          misc_prev_d;
  logic [SN-1:0]       gprev_d;
  logic [WEA_REG_W-1:0] st1_q, st1_d, st3_q, st3_d, st5_q, st5_d, st6_q, st6_d;
  logic [WEA_REG_W-1:0] ev1, ev3, ev5, ev6;
  logic [WEA_REG_W-1:0] ctl_q, ctl_d;
  logic [WEA_GPIO_N-1:0] gpio_ev;
  logic [WEA_EITHER_EDGE_IRQ_N-1:0] either_edge_irq_ev;
  logic                 group_st;
  logic                 wake_active;

  assign gsync.raw = {either_edge_irq_gpio_i, gpio_i};
  wea_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .port_if   (gsync)
  );

  // Edge detection on synchronised GPIOs
  genvar g;
  generate
    for (g = 0; g < WEA_GPIO_N; g++)
    begin : g_gpio
      assign gpio_ev[g] = !gpio_dir_out_i[g] &&
                          (gpio_pol_i[g] ? (gprev_q[g] && !gsync.synced[g])
                                         : (!gprev_q[g] && gsync.synced[g]));
    end
    for (g = 0; g < WEA_EITHER_EDGE_IRQ_N; g++)
    begin : g_either_edge_irq
      assign either_edge_irq_ev[g] = either_edge_irq_sel_i[g] &&
                          (gprev_q[WEA_GPIO_N+g] != gsync.synced[WEA_GPIO_N+g]);
    end
  endgenerate

  // Active-low pin sources, synchronised, falling edge is the event
  always_comb
  begin
    misc_meta_d = {hw_monitor_irq_n_i, ring_indicator_b_n_i, ring_indicator_a_n_i, power_button_n_i};
    misc_sync_d = misc_meta_q;
    misc_prev_d = misc_sync_q;
    gprev_d     = gsync.synced;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      misc_meta_q <= 4'hf;
      misc_sync_q <= 4'hf;
      misc_prev_q <= 4'hf;
      gprev_q     <= '0;
    end
    else
    begin
      misc_meta_q <= misc_meta_d;
      misc_sync_q <= misc_sync_d;
      misc_prev_q <= misc_prev_d;
      gprev_q     <= gprev_d;
    end
  end

  always_comb
  begin
    ev1 = '0;
    ev1[WEA_S1_PWRBTN] = misc_prev_q[0] && !misc_sync_q[0];
    ev1[WEA_S1_PLOSS]  = power_loss_event_i;
    ev1[WEA_S1_RI_A]   = misc_prev_q[1] && !misc_sync_q[1];
    ev1[WEA_S1_RI_B]   = misc_prev_q[2] && !misc_sync_q[2];
    ev1[WEA_S1_HWM]    = misc_prev_q[3] && !misc_sync_q[3];
    ev1[WEA_S1_WDT]    = watchdog_event_i;
    ev1[WEA_S1_LOWBAT] = main_por_event_i && low_battery_i;
    ev3 = '0;
    ev3[WEA_S3_GPIO]   = gpio_ev[0];
    ev5 = '0;
    ev5[WEA_GPIO_N-2:0] = gpio_ev[WEA_GPIO_N-1:1];
    ev6 = '0;
    ev6[WEA_S6_EETI0 +: WEA_EITHER_EDGE_IRQ_N] = either_edge_irq_ev;
    // Sticky, write-one clears, event wins
    st1_d = ev1 | (st1_q & ~wake_status_1_clr_i);
    st3_d = ev3 | (st3_q & ~wake_status_3_clr_i);
    st5_d = ev5 | (st5_q & ~wake_status_5_clr_i);
    st6_d = ev6 | (st6_q & ~wake_status_6_clr_i);
    ctl_d = pin_ctl_we_i ? pin_ctl_wdata_i : ctl_q;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      st1_q <= '0;
      st3_q <= '0;
      st5_q <= '0;
      st6_q <= '0;
      ctl_q <= WEA_PIN_CTL_RST;
    end
    else
    begin
      st1_q <= st1_d;
      st3_q <= st3_d;
      st5_q <= st5_d;
      st6_q <= st6_d;
      ctl_q <= ctl_d;
    end
  end

  // Group interrupt bit is a live mirror, gated by routing
  assign group_st = group_irq_i && mgmt_irq_enable_2_i;

  always_comb
  begin
    wake_status_3_o = st3_q;
    wake_status_3_o[WEA_S3_GROUP] = group_st;
  end

  assign wake_pin_status_o = |(st1_q & wake_enable_1_i) |
                             |(wake_status_3_o & wake_enable_3_i) |
                             |(st5_q & wake_enable_5_i) |
                             |(st6_q & wake_enable_6_i);
  assign wake_active = wake_pin_status_o && wake_pin_enable_i;

  // Pin drive: polarity bit set means active high
  always_comb
  begin
    if (wake_func_sel_i)
    begin
      if (ctl_q[WEA_CTL_OD])
      begin
        shared_wake_gpio_o    = 1'b0;
        shared_wake_gpio_oe_o = wake_active;
        if (ctl_q[WEA_CTL_POL])
        begin
          shared_wake_gpio_oe_o = !wake_active;
        end
      end
      else
      begin
        shared_wake_gpio_oe_o = 1'b1;
        shared_wake_gpio_o    = ctl_q[WEA_CTL_POL] ? wake_active : !wake_active;
      end
    end
    else
    begin
      shared_wake_gpio_o    = shared_wake_gpio_o_i;
      shared_wake_gpio_oe_o = shared_wake_gpio_oe_i;
    end
  end

  assign wake_status_1_o = st1_q;
  assign wake_status_5_o = st5_q;
  assign wake_status_6_o = st6_q;
  assign pin_ctl_o       = ctl_q;
endmodule
`default_nettype wire

// File: verification/wea_core_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module wea_core_assertions
  import wea_pkg::*;
(
  input wire logic       sys_clk_i,             // in
  input wire logic       reset_i,               // in
  input wire logic       watchdog_event_i,      // in
  input wire logic       group_irq_i,           // in
  input wire logic       mgmt_irq_enable_2_i,   // in
  input wire logic [7:0] wake_status_1_clr_i,   // in
  input wire logic [7:0] wake_enable_3_i,       // in
  input wire logic       wake_pin_enable_i,     // in
  input wire logic       wake_func_sel_i,       // in
  input wire logic [7:0] wake_status_1_o,       // out
  input wire logic [7:0] wake_status_3_o,       // out
  input wire logic       wake_pin_status_o,     // out
  input wire logic [7:0] pin_ctl_o,             // out
  input wire logic       shared_wake_gpio_o,    // out
  input wire logic       shared_wake_gpio_oe_o  // out
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  logic act;
  assign act = wake_func_sel_i && wake_pin_status_o && wake_pin_enable_i;
  a_event_sets: assert property (watchdog_event_i |=> wake_status_1_o[WEA_S1_WDT])
    else $error("event lost");
  a_status_sticky: assert property (wake_status_1_o[5] && !wake_status_1_clr_i[5] |=> wake_status_1_o[5])
    else $error("status dropped");
  a_clear_works: assert property (wake_status_1_clr_i[5] && !watchdog_event_i |=> !wake_status_1_o[5])
    else $error("clear ignored");
  a_group_mirror: assert property (wake_status_3_o[3] == (group_irq_i && mgmt_irq_enable_2_i))
    else $error("group mirror wrong");
  a_group_qual: assert property (wake_status_3_o[3] && wake_enable_3_i[3] |-> wake_pin_status_o)
    else $error("group not qualified");
  a_pin_low: assert property (act && !pin_ctl_o[1] |-> shared_wake_gpio_oe_o && !shared_wake_gpio_o)
    else $error("pin not asserted");
  a_od_release: assert property (wake_func_sel_i && pin_ctl_o[7] |->
    !shared_wake_gpio_o && shared_wake_gpio_oe_o == (act ^ pin_ctl_o[1]))
    else $error("open drain driven");
  a_polarity_high: assert property (act && pin_ctl_o[1] && !pin_ctl_o[7] |-> shared_wake_gpio_o)
    else $error("polarity ignored");
  a_reset_ctl: assert property ($fell(reset_i) |-> pin_ctl_o == WEA_PIN_CTL_RST)
    else $error("control reset wrong");
  cover property (watchdog_event_i && wake_status_1_clr_i[5]);
  cover property (act && pin_ctl_o[1]);
  cover property (wake_status_3_o[3] && wake_enable_3_i[3]);
endmodule
bind wea_core wea_core_assertions chk (.*);
`default_nettype wire

// File: verification/wea_chipset_model.sv
`timescale 1ns/1ns
`default_nettype none
module wea_chipset_model
(
  input  wire logic pin_o_i,  // Driven value
  input  wire logic pin_oe_i, // Driving
  output logic      line_o    // Line as seen
);
  // Released line floats to the pull-up
  assign line_o = pin_oe_i ? pin_o_i : 1'b1;
endmodule
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import wea_pkg::*;
  logic       sys_clk_i, reset_i, power_button_n_i, power_loss_event_i, ring_indicator_a_n_i, ring_indicator_b_n_i;
  logic       hw_monitor_irq_n_i, watchdog_event_i, low_battery_i, main_por_event_i, group_irq_i, mgmt_irq_enable_2_i;
  logic       wake_pin_enable_i, pin_ctl_we_i, wake_func_sel_i, shared_wake_gpio_o_i, shared_wake_gpio_oe_i, line;
  logic       wake_pin_status_o, shared_wake_gpio_o, shared_wake_gpio_oe_o;
  logic [1:0] either_edge_irq_gpio_i, either_edge_irq_sel_i;
  logic [7:0] gpio_i, gpio_dir_out_i, gpio_pol_i, wake_status_1_clr_i, wake_status_3_clr_i, wake_status_5_clr_i;
  logic [7:0] wake_status_6_clr_i, wake_enable_1_i, wake_enable_3_i, wake_enable_5_i, wake_enable_6_i, r;
  logic [7:0] pin_ctl_wdata_i, wake_status_1_o, wake_status_3_o, wake_status_5_o, wake_status_6_o, pin_ctl_o;
  logic [5:0][7:0] ob;
  logic [10:0] n;
  logic [10:0] q[$];
  int         errors, comparisons, cycles;
  string      nm[6] = '{"pin", "ctl", "st6", "st5", "st3", "st1"};
  wea_core dut (.*);
  wea_chipset_model chipset (.pin_o_i(shared_wake_gpio_o), .pin_oe_i(shared_wake_gpio_oe_o), .line_o(line));
  assign ob = {wake_status_1_o, wake_status_3_o, wake_status_5_o, wake_status_6_o, pin_ctl_o,
               5'h00, line, shared_wake_gpio_oe_o, wake_pin_status_o};
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk_i);
  endtask
  task automatic chk(input logic [2:0] s, input logic [7:0] e);
    q.push_back({s, e});
  endtask
  task automatic results;
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i)
    if (++cycles == 2000)
    begin
      errors++;
      results();
    end
  always @(negedge sys_clk_i)
    while (q.size() > 0)
    begin
      n = q.pop_front();
      comparisons++;
      if (ob[n[10:8]] !== n[7:0])
      begin
        errors++;
        $display("mismatch %s expected %h seen %h", nm[n[10:8]], n[7:0], ob[n[10:8]]);
      end
    end
  initial
  begin
    {reset_i, power_button_n_i, ring_indicator_a_n_i, ring_indicator_b_n_i, hw_monitor_irq_n_i} = '1;
    {power_loss_event_i, watchdog_event_i, low_battery_i, main_por_event_i, group_irq_i, mgmt_irq_enable_2_i} = '0;
    {wake_pin_enable_i, pin_ctl_we_i, wake_func_sel_i, shared_wake_gpio_o_i, shared_wake_gpio_oe_i, gpio_i} = '0;
    {gpio_dir_out_i, gpio_pol_i, either_edge_irq_gpio_i, either_edge_irq_sel_i, pin_ctl_wdata_i, wake_status_1_clr_i} = '0;
    {wake_status_3_clr_i, wake_status_5_clr_i, wake_status_6_clr_i, wake_enable_1_i, wake_enable_3_i} = '0;
    {wake_enable_5_i, wake_enable_6_i} = '0;
    r = 8'($urandom(33));
    cyc(20);
    {reset_i, shared_wake_gpio_oe_i, shared_wake_gpio_o_i} <= {2'b01, r[0]};
    cyc(1);
    chk(1, WEA_PIN_CTL_RST);
    chk(0, {5'h00, r[0], 2'b10});
    cyc(1);
    {wake_enable_1_i, wake_pin_enable_i, wake_func_sel_i, watchdog_event_i} <= 11'h107;
    cyc(1);
    wake_status_1_clr_i <= 8'h20;
    chk(5, 8'h20);
    chk(0, 8'h03);
    cyc(1);
    {watchdog_event_i, wake_status_1_clr_i} <= {1'b0, 8'hdf};
    chk(5, 8'h20);
    cyc(1);
    wake_status_1_clr_i <= 8'h20;
    chk(5, 8'h20);
    cyc(1);
    wake_status_1_clr_i <= 8'h00;
    chk(5, 8'h00);
    chk(0, 8'h04);
    {pin_ctl_we_i, pin_ctl_wdata_i} <= 9'h102;
    cyc(1);
    {pin_ctl_we_i, wake_enable_1_i, power_loss_event_i} <= 10'h005;
    chk(0, 8'h02);
    chk(1, 8'h02);
    cyc(1);
    power_loss_event_i <= 1'b0;
    chk(0, 8'h07);
    for (int j = 0; j < 4; j++)
    begin
      {hw_monitor_irq_n_i, ring_indicator_b_n_i, ring_indicator_a_n_i, power_button_n_i} <= ~(4'h1 << j);
      cyc(5);
      {hw_monitor_irq_n_i, ring_indicator_b_n_i, ring_indicator_a_n_i, power_button_n_i} <= 4'hf;
      cyc(4);
      chk(5, 8'h1f >> (3 - j));
    end
    low_battery_i <= 1'b1;
    cyc(3);
    main_por_event_i <= 1'b1;
    chk(5, 8'h1f);
    cyc(1);
    main_por_event_i <= 1'b0;
    chk(5, 8'h5f);
    {gpio_dir_out_i, gpio_i} <= 16'hffff;
    cyc(5);
    {gpio_dir_out_i, gpio_i} <= 16'h0000;
    chk(3, 8'h00);
    cyc(5);
    gpio_i <= 8'hff;
    cyc(5);
    chk(3, 8'h7f);
    chk(4, 8'h01);
    {wake_status_3_clr_i, wake_status_5_clr_i, gpio_pol_i} <= 24'h01ffff;
    cyc(1);
    {wake_status_3_clr_i, wake_status_5_clr_i} <= 16'h0000;
    r = 8'($urandom);
    gpio_i <= r;
    cyc(5);
    chk(3, {1'b0, ~r[7:1]});
    chk(4, {7'h00, ~r[0]});
    either_edge_irq_gpio_i <= 2'b11;
    cyc(5);
    {either_edge_irq_sel_i, either_edge_irq_gpio_i} <= 4'b1101;
    chk(2, 8'h00);
    cyc(5);
    wake_status_6_clr_i <= 8'hff;
    chk(2, 8'h02);
    cyc(1);
    {wake_status_6_clr_i, either_edge_irq_gpio_i} <= 10'h002;
    cyc(5);
    chk(2, 8'h03);
    {wake_enable_1_i, wake_enable_3_i, group_irq_i} <= 17'h00011;
    cyc(2);
    chk(4, {7'h00, ~r[0]});
    chk(0, 8'h02);
    cyc(1);
    mgmt_irq_enable_2_i <= 1'b1;
    cyc(1);
    chk(4, {4'h0, 1'b1, 2'h0, ~r[0]});
    chk(0, 8'h07);
    cyc(1);
    group_irq_i <= 1'b0;
    cyc(1);
    chk(0, 8'h02);
    chk(4, {7'h00, ~r[0]});
    cyc(1);
    results();
  end
endmodule
`default_nettype wire
